//--- hw/abz_consts.svh
// constants for the angle quadrature and pulse-width output stage
`ifndef ABZ_CONSTS_SVH
`define ABZ_CONSTS_SVH
`define ANGLE_W 14
`define EDGE_W 12
`define EDGE_CNT_W 13
`define PPT_W 10
`define HYS_CODE_W 8
`define SHAPE_W 4
`define CLK_HZ 10000000
`define ABZ_UPDATE_HZ 16000000
`define ABZ_UPDATE_CYCLES (((`CLK_HZ / `ABZ_UPDATE_HZ) < 1) ? 1 : (`CLK_HZ / `ABZ_UPDATE_HZ))
`define HYS_CODE_0P08 8'hC8
`define HYS_CODE_0P14 8'hBC
`define HYS_CODE_0P18 8'h94
`define HYS_CODE_0P36 8'h98
`define HYS_CODE_0P52 8'h9C
`define HYS_CODE_0P70 8'h74
`define HYS_CODE_1P4 8'h78
`define HYS_CODE_2P1 8'h7C
`define HYS_CODE_2P8 8'h54
`define HYS_LSB_0P08 8'h04
`define HYS_LSB_0P14 8'h06
`define HYS_LSB_0P18 8'h08
`define HYS_LSB_0P36 8'h10
`define HYS_LSB_0P52 8'h18
`define HYS_LSB_0P70 8'h20
`define HYS_LSB_1P4 8'h40
`define HYS_LSB_2P1 8'h60
`define HYS_LSB_2P8 8'h7F
`define PWM_FRAME_UNITS 514
`define PWM_UNIT_CYCLES 32
`define PWM_CNT_W 15
`define PWM_MIN_HIGH 15'h0020
`endif

//--- hw/abz_pkg.sv
// types shared by the quadrature and pulse-width output stage
package abz_pkg;
    typedef enum logic {dir_fwd, dir_rev} dir_type;
endpackage : abz_pkg

//--- hw/pwm_link_if.sv
// carrier between the core and its pulse-width generator
`timescale 1ns/1ns
`include "abz_consts.svh"
interface pwm_link_if;
    logic [`ANGLE_W-1:0] angle;
    logic level;
    logic frame_start;
    modport core (output angle, input level, input frame_start);
    modport gen (input angle, output level, output frame_start);
endinterface : pwm_link_if

//--- hw/pwm_absolute_gen.sv
// absolute pulse-width generator, duty rising linearly with angle
`timescale 1ns/1ns
`include "abz_consts.svh"
module pwm_absolute_gen
    import abz_pkg::*;
#(
    parameter int PERIOD_CYCLES = `PWM_FRAME_UNITS * `PWM_UNIT_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // link to core
    pwm_link_if.gen link
);
    logic [`PWM_CNT_W-1:0] cnt;
    logic [`PWM_CNT_W-1:0] high_len;
    logic level;
    logic frame_start;
    wire last_cycle = (cnt == `PWM_CNT_W'(PERIOD_CYCLES - 1));
    // angle taken once per frame so a frame never carries two duties
    wire [`PWM_CNT_W-1:0] next_high_len = `PWM_MIN_HIGH + `PWM_CNT_W'(link.angle);
    wire [`PWM_CNT_W-1:0] next_cnt = last_cycle ? '0 : cnt + `PWM_CNT_W'(1);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cnt <= `PWM_CNT_W'(PERIOD_CYCLES - 1); // park at frame end: first frame is whole
            high_len <= `PWM_MIN_HIGH;
            level <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            cnt <= next_cnt;
            frame_start <= last_cycle;
            if (last_cycle) begin
                high_len <= next_high_len;
            end
            level <= (next_cnt < (last_cycle ? next_high_len : high_len));
        end
    end

    assign link.level = level;
    assign link.frame_start = frame_start;

    pwm_min_high_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        $rose(level) |-> level [*8])
        else $error("pulse high shorter than minimum");
    pwm_frame_start_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        frame_start && $past(frame_start) == 1'b0 |-> level)
        else $error("frame does not open high");
endmodule : pwm_absolute_gen

//--- hw/angle_abz_pwm_output.sv
// angle to quadrature a/b/z and absolute pulse-width outputs
//
// Function
// - hysteresis from 8-bit code, default 0.52 deg
// - quadrature state recomputed at update rate
// - edges at least one update period apart
// - pulse output high fraction rises with angle
// - high time between 1/514 and 513/514
// - duty steps of one part in 16448
// - zero angle minimum, full code maximum duty
// - pulses per turn equals code plus one
// - b lags a by quarter pulse
// - index once per turn, starting 0 to 3 edges past zero angle per shape code low bits
`timescale 1ns/1ns
`include "abz_consts.svh"
module angle_abz_pwm_output
    import abz_pkg::*;
#(
    parameter int PWM_PERIOD_CYCLES = `PWM_FRAME_UNITS * `PWM_UNIT_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // filtered absolute angle
    input wire logic [`ANGLE_W-1:0] angle_i,
    // configuration
    input wire logic [`HYS_CODE_W-1:0] incremental_hysteresis_code_i,
    input wire logic [`PPT_W-1:0] pulses_per_turn_code_i,
    input wire logic [`SHAPE_W-1:0] index_shape_code_i,
    // encoder outputs
    output logic a_o,
    output logic b_o,
    output logic z_o,
    // absolute pulse output
    output logic pwm_o
);
    function automatic logic [7:0] hys_lsb(input logic [`HYS_CODE_W-1:0] code);
        case (code)
            `HYS_CODE_0P08: hys_lsb = `HYS_LSB_0P08;
            `HYS_CODE_0P14: hys_lsb = `HYS_LSB_0P14;
            `HYS_CODE_0P18: hys_lsb = `HYS_LSB_0P18;
            `HYS_CODE_0P36: hys_lsb = `HYS_LSB_0P36;
            `HYS_CODE_0P70: hys_lsb = `HYS_LSB_0P70;
            `HYS_CODE_1P4: hys_lsb = `HYS_LSB_1P4;
            `HYS_CODE_2P1: hys_lsb = `HYS_LSB_2P1;
            `HYS_CODE_2P8: hys_lsb = `HYS_LSB_2P8;
            default: hys_lsb = `HYS_LSB_0P52;
        endcase
    endfunction : hys_lsb

    // edge position of an angle for the current edges per turn
    function automatic logic [`EDGE_W-1:0] edge_index(input logic [`ANGLE_W-1:0] ang,
                                                      input logic [`EDGE_CNT_W-1:0] e);
        logic [`ANGLE_W+`EDGE_CNT_W-1:0] p;
        p = ang * e;
        edge_index = p[`ANGLE_W+`EDGE_W-1:`ANGLE_W];
    endfunction : edge_index

    // forward distance from q to t, modulo the edges per turn
    function automatic logic [`EDGE_CNT_W-1:0] wrap_diff(input logic [`EDGE_W-1:0] t,
                                                         input logic [`EDGE_W-1:0] q,
                                                         input logic [`EDGE_CNT_W-1:0] e);
        logic [`EDGE_CNT_W-1:0] d;
        d = {1'b0, t} - {1'b0, q};
        if (d[`EDGE_CNT_W-1]) begin
            d = d + e;
        end
        wrap_diff = d;
    endfunction : wrap_diff

    localparam int UPD_CYCLES = `ABZ_UPDATE_CYCLES;
    localparam int UPD_W = (UPD_CYCLES > 1) ? $clog2(UPD_CYCLES) : 1;

    logic [UPD_W-1:0] upd_cnt;
    logic [`EDGE_W-1:0] q;
    dir_type dir;
    logic primed;
    logic a_q;
    logic b_q;
    logic z_q;

    // update enable; at a 10 MHz clock every cycle is already longer than the 16 MHz period
    wire upd_en = (upd_cnt == UPD_W'(UPD_CYCLES - 1));

    // four edges per pulse, pulses = code + 1
    wire [`EDGE_CNT_W-1:0] edges = {1'b0, pulses_per_turn_code_i, 2'b00}
        + `EDGE_CNT_W'(4);
    wire [`EDGE_CNT_W-1:0] half_edges = edges >> 1;
    wire [`ANGLE_W-1:0] incremental_hysteresis_code = `ANGLE_W'(hys_lsb(incremental_hysteresis_code_i));
    wire [`EDGE_W-1:0] raw_idx = edge_index(angle_i, edges);
    wire [`EDGE_W-1:0] lo_idx = edge_index(angle_i - incremental_hysteresis_code, edges);
    wire [`EDGE_W-1:0] hi_idx = edge_index(angle_i + incremental_hysteresis_code, edges);
    // the direction last taken moves freely; the opposite needs hysteresis
    wire [`EDGE_W-1:0] fwd_tgt = (dir == dir_fwd) ? raw_idx : lo_idx;
    wire [`EDGE_W-1:0] rev_tgt = (dir == dir_rev) ? raw_idx : hi_idx;
    wire [`EDGE_CNT_W-1:0] fwd_diff = wrap_diff(fwd_tgt, q, edges);
    wire [`EDGE_CNT_W-1:0] rev_diff = wrap_diff(rev_tgt, q, edges);
    wire step_fwd = (fwd_diff != '0) && (fwd_diff < half_edges);
    wire step_rev = !step_fwd && (rev_diff >= half_edges);
    wire q_out_range = ({1'b0, q} >= edges);
    wire [`EDGE_W-1:0] last_q = `EDGE_W'(edges - `EDGE_CNT_W'(1));
    // one step per update, so a fast shaft never packs edges closer
    wire [`EDGE_W-1:0] next_q = q_out_range ? raw_idx
        : step_fwd ? ((q == last_q) ? '0 : q + `EDGE_W'(1))
        : step_rev ? ((q == '0) ? last_q : q - `EDGE_W'(1))
        : q;

    // phase: 00 -> a rises -> b rises -> a falls -> b falls
    wire [1:0] next_phase = next_q[1:0];
    wire next_a = next_phase[0] ^ next_phase[1];
    wire next_b = next_phase[1];

    // index: start quarter from low bits, length from high bits
    wire [1:0] z_len_sel = index_shape_code_i[3:2];
    wire [`EDGE_CNT_W-1:0] z_len = (z_len_sel == 2'b00) ? `EDGE_CNT_W'(2)
        : (z_len_sel == 2'b01) ? `EDGE_CNT_W'(1)
        : (z_len_sel == 2'b10) ? `EDGE_CNT_W'(3) : `EDGE_CNT_W'(4);
    wire [`EDGE_W-1:0] z_start = `EDGE_W'(index_shape_code_i[1:0]);
    wire next_z = (wrap_diff(next_q, z_start, edges) < z_len);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            upd_cnt <= '0;
        end else begin
            upd_cnt <= upd_en ? '0 : upd_cnt + UPD_W'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            q <= '0;
            dir <= dir_fwd;
            primed <= 1'b0;
            a_q <= 1'b0;
            b_q <= 1'b0;
            z_q <= 1'b0;
        end else if (upd_en) begin
            // first update loads position directly, no edge burst after reset
            q <= primed ? next_q : raw_idx;
            primed <= 1'b1;
            if (primed && step_fwd) begin
                dir <= dir_fwd;
            end else if (primed && step_rev) begin
                dir <= dir_rev;
            end
            a_q <= primed ? next_a : (raw_idx[0] ^ raw_idx[1]);
            b_q <= primed ? next_b : raw_idx[1];
            z_q <= primed ? next_z : (wrap_diff(raw_idx, z_start, edges) < z_len);
        end
    end

    pwm_link_if link ();
    assign link.angle = angle_i;

    pwm_absolute_gen #(
        .PERIOD_CYCLES(PWM_PERIOD_CYCLES)
    ) u_pwm (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .link(link.gen)
    );

    assign a_o = a_q;
    assign b_o = b_q;
    assign z_o = z_q;
    assign pwm_o = link.level;

    // frame length counted outside the generator; the count ending at the first frame start is not judged
    logic [`PWM_CNT_W-1:0] frame_len;
    logic frame_seen;
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            frame_len <= '0;
            frame_seen <= 1'b0;
        end else begin
            frame_len <= u_pwm.frame_start ? `PWM_CNT_W'(1) : frame_len + `PWM_CNT_W'(1);
            frame_seen <= frame_seen || u_pwm.frame_start;
        end
    end

    ab_single_edge_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        primed && $past(primed) |-> !(($past(a_q) != a_q) && ($past(b_q) != b_q)))
        else $error("a and b changed together");
    edge_on_update_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ((a_q != $past(a_q)) || (b_q != $past(b_q))) |-> $past(upd_en))
        else $error("quadrature edge outside update");
    edge_spacing_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        primed && (q != $past(q)) |-> ##1 ((q == $past(q)) || $past(upd_en)))
        else $error("edges closer than update period");
    q_in_range_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        primed && $stable(pulses_per_turn_code_i) && $past(primed) |-> ({1'b0, q} < edges))
        else $error("position beyond edges per turn");
    index_at_zero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        primed && (index_shape_code_i == 4'h0) |-> (z_q == (q < `EDGE_W'(2))))
        else $error("index not at zero position");
    rev_hysteresis_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        upd_en && primed && dir == dir_fwd && !q_out_range && wrap_diff(hi_idx, q, edges) == '0
        |=> dir == dir_fwd)
        else $error("reverse edge within hysteresis");
    hys_default_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        incremental_hysteresis_code_i == `HYS_CODE_0P52 |-> incremental_hysteresis_code == `ANGLE_W'(`HYS_LSB_0P52))
        else $error("default hysteresis code misdecoded");
    pwm_zero_angle_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        u_pwm.frame_start && $past(angle_i) == '0 && $past(u_pwm.frame_start, 2) == 1'b0
        |-> u_pwm.high_len == `PWM_MIN_HIGH)
        else $error("zero angle not at minimum duty");
    one_step_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        primed && $past(primed) && $stable(pulses_per_turn_code_i) && !$past(q_out_range)
        |-> (q == $past(q)) || (wrap_diff(q, $past(q), edges) == `EDGE_CNT_W'(1))
            || (wrap_diff($past(q), q, edges) == `EDGE_CNT_W'(1)))
        else $error("more than one edge per update");
    z_rise_b_fall_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        primed && $past(primed) && index_shape_code_i == 4'h0 && $stable(index_shape_code_i)
        && $stable(pulses_per_turn_code_i) && !$past(q_out_range) && $rose(z_q) |-> $fell(b_q))
        else $error("index rise not on b falling edge");
    fwd_hysteresis_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        upd_en && primed && dir == dir_rev && !q_out_range && wrap_diff(lo_idx, q, edges) == '0
        |=> dir == dir_rev)
        else $error("forward edge within hysteresis");
    pwm_full_scale_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        u_pwm.frame_start && $past(angle_i) == '1
        |-> u_pwm.high_len == `PWM_MIN_HIGH + `PWM_CNT_W'({`ANGLE_W{1'b1}}))
        else $error("full scale angle not at maximum duty");
    pwm_high_bound_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        u_pwm.high_len >= `PWM_MIN_HIGH
        && u_pwm.high_len <= `PWM_CNT_W'(PWM_PERIOD_CYCLES) - `PWM_MIN_HIGH)
        else $error("pulse high time outside bounds");
    pwm_frame_len_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        u_pwm.frame_start && frame_seen |-> frame_len == `PWM_CNT_W'(PWM_PERIOD_CYCLES))
        else $error("pulse period not constant");
endmodule : angle_abz_pwm_output

//--- dv/abz_counter_model.sv
// servo-side model: quadrature counter, index watcher and pulse timer
`timescale 1ns/1ns
module abz_counter_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // encoder and pulse lines
    input wire logic a_i,
    input wire logic b_i,
    input wire logic z_i,
    input wire logic pwm_i,
    // observations
    output int count_o,
    output int bad_o,
    output int z_rises_o,
    output int zb_bad_o,
    output int high_o,
    output int low_o,
    output int periods_o
);
    logic aq, bq, zq, pq, rq, rq2;
    int hc, lc;
    wire logic [1:0] st_old = {bq, aq ^ bq};
    wire logic [1:0] st_new = {b_i, a_i ^ b_i};
    wire logic [1:0] st_step = st_new - st_old;
    // sampled every cycle, so edges one update apart are taken
    always @(posedge core_clk_i) begin
        {aq, bq, zq, pq, rq, rq2} <= {a_i, b_i, z_i, pwm_i, reset_i, rq};
        if (reset_i) begin
            count_o <= 0;
            bad_o <= 0;
            z_rises_o <= 0;
            zb_bad_o <= 0;
            periods_o <= 0;
            hc <= 0;
            lc <= 0;
        end else if (!rq) begin
            // first update after reset loads position, it is not motion
            if (!rq2) begin
                if (st_step == 2'h1) count_o <= count_o + 1;
                if (st_step == 2'h3) count_o <= count_o - 1;
                if (st_step == 2'h2) bad_o <= bad_o + 1;
                if (z_i && !zq) z_rises_o <= z_rises_o + 1;
                if (z_i && !zq && !(bq && !b_i)) zb_bad_o <= zb_bad_o + 1;
            end
            // both times measured: the period is not trusted
            if (pwm_i && !pq) begin
                high_o <= hc;
                low_o <= lc;
                periods_o <= periods_o + 1;
                hc <= 1;
                lc <= 0;
            end else if (pwm_i) hc <= hc + 1;
            else lc <= lc + 1;
        end
    end
endmodule : abz_counter_model

//--- dv/angle_abz_pwm_output_test.sv
// self-checking bench for the quadrature and pulse-width output stage
`timescale 1ns/1ns
`include "abz_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %0d exp %0d", $time, g, e); end end
module angle_abz_pwm_output_test;
    logic core_clk_i = 0, reset_i = 1;
    logic [13:0] angle_i = 14'h0000;
    logic [7:0] hys_i = `HYS_CODE_0P52;
    logic [9:0] ppt_i = 10'h003;
    logic [3:0] shape_i = 4'h0;
    logic a_o, b_o, z_o, pwm_o;
    int count, bad, z_rises, zb_bad, high, low, periods;
    int n_fail = 0, checks = 0, cyc = 0;
    logic [7:0] hcode [9] = '{`HYS_CODE_0P08, `HYS_CODE_0P14, `HYS_CODE_0P18,
        `HYS_CODE_0P36, `HYS_CODE_0P52, `HYS_CODE_0P70, `HYS_CODE_1P4,
        `HYS_CODE_2P1, `HYS_CODE_2P8};
    logic [7:0] hlsb [9] = '{`HYS_LSB_0P08, `HYS_LSB_0P14, `HYS_LSB_0P18,
        `HYS_LSB_0P36, `HYS_LSB_0P52, `HYS_LSB_0P70, `HYS_LSB_1P4,
        `HYS_LSB_2P1, `HYS_LSB_2P8};
    always #50 core_clk_i = ~core_clk_i;
    angle_abz_pwm_output u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .angle_i(angle_i), .incremental_hysteresis_code_i(hys_i),
        .pulses_per_turn_code_i(ppt_i), .index_shape_code_i(shape_i),
        .a_o(a_o), .b_o(b_o), .z_o(z_o), .pwm_o(pwm_o));
    abz_counter_model u_far (.core_clk_i(core_clk_i), .reset_i(reset_i), .a_i(a_o),
        .b_i(b_o), .z_i(z_o), .pwm_i(pwm_o), .count_o(count), .bad_o(bad),
        .z_rises_o(z_rises), .zb_bad_o(zb_bad), .high_o(high), .low_o(low),
        .periods_o(periods));
    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // a fresh reset reloads position, so each scenario starts clean
    task automatic do_reset(input logic [9:0] p, input logic [7:0] h, input logic [13:0] ang);
        @(posedge core_clk_i);
        reset_i <= 1;
        ppt_i <= p;
        hys_i <= h;
        angle_i <= ang;
        repeat (6) @(posedge core_clk_i);
        `CHK({a_o, b_o, z_o, pwm_o}, 4'h0)
        reset_i <= 0;
        repeat (3) @(posedge core_clk_i);
    endtask : do_reset
    task automatic wait_period(input int n);
        for (int i = 0; i < 20000 && periods < n; i++) @(posedge core_clk_i);
    endtask : wait_period
    task automatic pwm_extremes();
        do_reset(10'h003, `HYS_CODE_0P52, 14'h0000);
        wait_period(1);
        angle_i <= 14'h3FFF;
        wait_period(2);
        `CHK(high, 32)
        `CHK(low, 16416)
        wait_period(3);
        `CHK(high, 16415)
        `CHK(low, 33)
    endtask : pwm_extremes
    task automatic full_turn(input logic [9:0] p, input logic [3:0] s, input int zb);
        shape_i <= s;
        do_reset(p, `HYS_CODE_0P52, 14'h0001);
        repeat (8192) @(posedge core_clk_i) angle_i <= angle_i + 14'h0002;
        repeat (20) @(posedge core_clk_i);
        `CHK(count, 4 * (p + 1))
        `CHK(bad, 0)
        `CHK(z_rises, 1)
        `CHK(zb_bad, zb)
    endtask : full_turn
    task automatic hysteresis(input logic [7:0] h, input int lsb);
        do_reset(10'h003, h, 14'd900);
        angle_i <= 14'd1324;
        repeat (5) @(posedge core_clk_i);
        `CHK(count, 1)
        angle_i <= 14'(1024 - lsb + 3);
        repeat (5) @(posedge core_clk_i);
        `CHK(count, 1)
        angle_i <= 14'(1024 - lsb - 3);
        repeat (5) @(posedge core_clk_i);
        `CHK(count, 0)
        angle_i <= 14'(1024 + lsb - 3);
        repeat (5) @(posedge core_clk_i);
        `CHK(count, 0)
        angle_i <= 14'(1024 + lsb + 3);
        repeat (5) @(posedge core_clk_i);
        `CHK(count, 1)
    endtask : hysteresis
    task automatic big_jump();
        do_reset(10'h003, `HYS_CODE_0P52, 14'h0000);
        angle_i <= 14'd4106;
        repeat (12) @(posedge core_clk_i);
        `CHK(count, 4)
        `CHK(bad, 0)
    endtask : big_jump
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        pwm_extremes();
        full_turn(10'h000, 4'h0, 0);
        full_turn(10'h003, 4'h0, 0);
        full_turn(10'h3FF, 4'h0, 0);
        full_turn(10'h003, 4'h7, 1);
        for (int i = 0; i < 9; i++) hysteresis(hcode[i], int'(hlsb[i]));
        big_jump();
        test_done();
    end
endmodule : angle_abz_pwm_output_test
